// File: bench/mfp_conv.sv
// converter model outside one pin
`default_nettype none
module mfp_conv #(
    parameter int LAT = 3,
    parameter logic [15:0] VAL = 16'h1234
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request and result
    input wire logic start,
    output logic [15:0] data,
    output logic valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // result stands one cycle, inverted otherwise so a late sample shows
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= 0;
            valid <= 1'b0;
            data <= ~VAL;
        end else begin
            valid <= (cnt == 1);
            data <= (cnt == 1) ? VAL : ~VAL;
            cnt <= start ? LAT : (cnt != 0 ? cnt - 1 : 0);
        end
    end
endmodule // mfp_conv
`default_nettype wire

// File: bench/mfp_top_asserts.sv
// port assertions for the pin function block
`default_nettype none
module mfp_top_asserts (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // bus answer
    input wire logic hreadyout,
    input wire logic hresp,
    // pin results
    input wire logic pin_one_adc_start_q,
    input wire logic pin_four_adc_start_q,
    input wire logic wind_speed_ao_en_q,
    input wire logic pin_one_ao_drive_q,
    input wire logic pin_four_ao_drive_q,
    input wire logic half_duplex_q,
    input wire logic full_duplex_ok_q,
    input wire logic [1:0] instrument_id_bit_q,
    input wire logic [1:0] instrument_id_valid_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_OKAY: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    AST_BOOT: assert property ($rose(hresetn) |-> full_duplex_ok_q)
        else $error("codes not zero after reset");
    AST_NOCONV: assert property (!half_duplex_q [*3]
        |-> !pin_one_adc_start_q && !pin_four_adc_start_q)
        else $error("conversion in full duplex");
    AST_ONE_PULSE: assert property (pin_one_adc_start_q |=> !pin_one_adc_start_q)
        else $error("pin one request not a pulse");
    AST_FOUR_PULSE: assert property ($rose(pin_four_adc_start_q) |=> $fell(pin_four_adc_start_q))
        else $error("pin four request not a pulse");
    AST_IDLE: assert property (full_duplex_ok_q [*3]
        |-> !pin_one_ao_drive_q && !pin_four_ao_drive_q)
        else $error("unused pin driven");
    AST_ID_ONE: assert property (instrument_id_bit_q[0] |-> instrument_id_valid_q[0])
        else $error("id bit 0 without selection");
    AST_ID_FOUR: assert property ($rose(instrument_id_bit_q[1]) |-> instrument_id_valid_q[1])
        else $error("id bit 1 without selection");
    AST_SPEED: assert property ($rose(pin_one_ao_drive_q) |-> ##[0:2] wind_speed_ao_en_q)
        else $error("pin one driven with speed output off");
endmodule // mfp_top_asserts
bind mfp_top mfp_top_asserts u_chk (.hclk, .hresetn, .hreadyout, .hresp,
    .pin_one_adc_start_q, .pin_four_adc_start_q, .wind_speed_ao_en_q,
    .pin_one_ao_drive_q, .pin_four_ao_drive_q, .half_duplex_q, .full_duplex_ok_q,
    .instrument_id_bit_q, .instrument_id_valid_q);
`default_nettype wire

// File: bench/mfp_top_test.sv
// register tests of the pin function block
`default_nettype none
`include "mfp_map.vh"
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("unexpected %s exp %h got %h", n, e, a); end end
module mfp_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] V1 = 16'h5a3c;
    localparam logic [15:0] V4 = 16'hc3a5;
    localparam logic [7:0] A_CT = `MFP_CTRL_OFS;
    localparam logic [7:0] A_P1 = `MFP_PIN_ONE_FUNC_OFS;
    localparam logic [7:0] A_P4 = `MFP_PIN_FOUR_FUNC_OFS;
    int errors = 0;
    int check_count = 0;
    logic hclk = 0, hresetn = 0, hwrite = 0, pin1 = 0, pin4 = 0;
    logic [7:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata;
    logic hreadyout, hresp, st1, st4, v1, v4, spd, dir, drv1, drv4, hdx, fdok;
    logic [15:0] d1, d4, tel;
    logic [1:0] idb, idv;
    always #2 hclk = ~hclk;
    mfp_top #(.SAMPLE_PERIOD_NS(40)) u_dut (.hclk, .hresetn, .ce(1'b1), .hsel(1'b1),
        .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .pin_one_in(pin1), .pin_four_in(pin4),
        .pin_one_adc_data(d1), .pin_one_adc_valid(v1), .pin_four_adc_data(d4),
        .pin_four_adc_valid(v4), .pin_one_adc_start_q(st1), .pin_four_adc_start_q(st4),
        .wind_speed_ao_en_q(spd), .wind_direction_ao_en_q(dir),
        .pin_one_ao_drive_q(drv1), .pin_four_ao_drive_q(drv4), .half_duplex_q(hdx),
        .full_duplex_ok_q(fdok), .instrument_id_bit_q(idb), .instrument_id_valid_q(idv),
        .telegram_field_q(tel));
    mfp_conv #(.VAL(V1)) u_c1 (.hclk, .hresetn, .start(st1), .data(d1), .valid(v1));
    mfp_conv #(.VAL(V4)) u_c4 (.hclk, .hresetn, .start(st4), .data(d4), .valid(v4));
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        `CHK("read", e, r)
    endtask
    task automatic pins(input logic [1:0] c);
        wr(A_P1, {30'h0, c});
        wr(A_P4, {30'h0, c});
        repeat (30) @(posedge hclk);
    endtask
    initial begin
        repeat (5000) @(posedge hclk);
        errors++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        `CHK("fdok", 1'b1, fdok)
        rchk(A_P4, 32'h0);
        wr(A_P1, 32'h1);
        rchk(A_P1, 32'h0);
        wr(A_CT, 32'h1);
        for (int c = 0; c < 8; c++) begin
            wr(A_P1, 32'(c));
            wr(A_P4, 32'(c));
            rchk(A_P1, 32'(c > 4 ? 4 : c));
            rchk(A_P4, 32'(c > 4 ? 4 : c));
        end
        pins(2'd1);
        `CHK("half", 1'b1, hdx)
        rchk(`MFP_PIN_ONE_VALUE_OFS, {16'h0, V1});
        rchk(`MFP_PIN_FOUR_VALUE_OFS, {16'h0, V4});
        `CHK("outputs off", 2'b00, {dir, spd})
        pins(2'd2); // voltage mode set first
        `CHK("tele one", V1, tel)
        `CHK("drive", 2'b11, {drv4, drv1})
        wr(A_CT, 32'h11);
        repeat (4) @(posedge hclk);
        `CHK("tele four", V4, tel)
        rchk(`MFP_TELEGRAM_OFS, {16'h0, V4});
        pins(2'd3);
        `CHK("drive on", 4'hf, {dir, spd, drv4, drv1})
        wr(A_CT, 32'h5);
        repeat (4) @(posedge hclk);
        `CHK("drive off", 2'b00, {drv4, drv1})
        wr(A_CT, 32'h9); // mode 0, external id select on
        wr(A_P1, 32'h4);
        wr(A_P4, 32'h4);
        pin1 <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK("id one", 2'b01, idb)
        `CHK("id valid", 2'b11, idv)
        pin1 <= 1'b0;
        pin4 <= 1'b1;
        repeat (6) @(posedge hclk);
        `CHK("id four", 2'b10, idb)
        wr(A_CT, 32'h0);
        wr(A_P1, 32'h0);
        rchk(A_P1, 32'h4);
        `CHK("id off", 2'b00, idb)
        `CHK("id valid off", 2'b00, idv)
        wr(A_CT, 32'h1);
        pins(2'd0);
        `CHK("fdok", 1'b1, fdok)
        rchk(`MFP_STATUS_OFS, 32'h39);
        rchk(8'h40, 32'h0);
        summarize();
    end
endmodule // mfp_top_test
`default_nettype wire

// File: rtl/mfp_map.vh
// register map, field positions, reset values and timing for the pin function block
`ifndef MFP_MAP_VH
`define MFP_MAP_VH
// register byte offsets
`define MFP_CTRL_OFS 8'h00
`define MFP_PIN_ONE_FUNC_OFS 8'h04
`define MFP_PIN_FOUR_FUNC_OFS 8'h08
`define MFP_STATUS_OFS 8'h0c
`define MFP_PIN_ONE_VALUE_OFS 8'h10
`define MFP_PIN_FOUR_VALUE_OFS 8'h14
`define MFP_TELEGRAM_OFS 8'h18
// control fields
`define MFP_CTRL_HALF_BIT 0
`define MFP_CTRL_AN_LO 1
`define MFP_CTRL_AN_HI 2
`define MFP_CTRL_XID_BIT 3
`define MFP_CTRL_TEL_BIT 4
`define MFP_CTRL_RESET 5'h00
// function codes
`define MFP_CODE_UNUSED 3'h0
`define MFP_CODE_AIN 3'h1
`define MFP_CODE_TEST 3'h2
`define MFP_CODE_AOUT 3'h3
`define MFP_CODE_ID 3'h4
`define MFP_CODE_MAX 3'h4
`define MFP_CODE_RESET 3'h0
`define MFP_AN_OFF 2'h2
// cyclic conversion period
`define MFP_SAMPLE_PERIOD_NS 1000
`define MFP_CLK_PERIOD_NS 4
`define MFP_SAMPLE_WIDTH 16
`endif

// File: rtl/mfp_pin.v
// behaviour of one multi-function pin for a given function code
`default_nettype none
`include "mfp_map.vh"
module mfp_pin #(
    parameter PERIOD = 250,
    parameter W = `MFP_SAMPLE_WIDTH
) (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // configuration
    input wire [2:0] code,
    input wire half_duplex,
    input wire [1:0] an_mode,
    input wire ext_id_sel,
    // synchronised pin level and converter
    input wire pin_level,
    input wire [W-1:0] adc_data,
    input wire adc_valid,
    // results
    output reg adc_start_q,
    output reg [W-1:0] value_q,
    output reg [W-1:0] selftest_q,
    output reg ao_off_q,
    output reg ao_drive_q,
    output reg id_bit_q,
    output reg id_valid_q
);
    localparam CW = 16;
    localparam [31:0] LAST_FULL = PERIOD - 1;
    reg [CW-1:0] cnt_q;
    wire in_mode = (code == `MFP_CODE_AIN) && half_duplex;
    wire test_mode = (code == `MFP_CODE_TEST) && half_duplex;
    wire tick = (cnt_q == LAST_FULL[CW-1:0]);
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= {CW{1'b0}};
            adc_start_q <= 1'b0;
            value_q <= {W{1'b0}};
            selftest_q <= {W{1'b0}};
            ao_off_q <= 1'b0;
            ao_drive_q <= 1'b0;
            id_bit_q <= 1'b0;
            id_valid_q <= 1'b0;
        end else if (ce) begin
            cnt_q <= tick ? {CW{1'b0}} : cnt_q + 1'b1;
            // cyclic conversion request
            adc_start_q <= tick && (in_mode || test_mode);
            if (adc_valid && in_mode)
                value_q <= adc_data;
            if (adc_valid && test_mode)
                selftest_q <= adc_data;
            // analog input takes the pin away from the analog output
            ao_off_q <= (code == `MFP_CODE_AIN);
            ao_drive_q <= ((code == `MFP_CODE_AOUT) || test_mode)
                && (an_mode != `MFP_AN_OFF);
            id_valid_q <= (code == `MFP_CODE_ID) && ext_id_sel;
            id_bit_q <= (code == `MFP_CODE_ID) && ext_id_sel && pin_level;
        end
    end
endmodule // mfp_pin
`default_nettype wire

// File: rtl/mfp_sync.v
// two flip-flop synchroniser for a pin level
`default_nettype none
module mfp_sync (
    // clock and reset
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // level in and out
    input wire d,
    output reg q
);
    reg meta_q;
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= 1'b0;
            q <= 1'b0;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // mfp_sync
`default_nettype wire

// File: rtl/mfp_top.v
// multi-function pin configuration block with its AHB-Lite register slave
//
// Behaviour
// - two function codes 0..4, reset to 0
// - code writes accepted only in half duplex
// - pin one code 0: unused, full duplex allowed
// - pin one code 1: cyclic 16-bit input, speed output off
// - input and self test need half duplex
// - pin one code 2: speed output read back
// - self-test value selectable telegram field
// - pin one code 3: speed output unless mode 2
// - pin one code 4: external id bit 0
// - pin four code 0: unused, full duplex allowed
// - pin four code 1: cyclic input, direction output off
// - pin four code 2: direction output read back
// - pin four code 3: direction output unless mode 2
// - pin four code 4: external id bit 1
`default_nettype none
`include "mfp_map.vh"
module mfp_top #(
    parameter SAMPLE_PERIOD_NS = `MFP_SAMPLE_PERIOD_NS,
    parameter W = `MFP_SAMPLE_WIDTH
) (
    // clock, reset and enable
    input wire hclk,
    input wire hresetn,
    input wire ce,
    // ahb-lite slave
    input wire hsel,
    input wire [7:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    // pin levels from outside
    input wire pin_one_in,
    input wire pin_four_in,
    // on-chip input converters
    input wire [W-1:0] pin_one_adc_data,
    input wire pin_one_adc_valid,
    input wire [W-1:0] pin_four_adc_data,
    input wire pin_four_adc_valid,
    output wire pin_one_adc_start_q,
    output wire pin_four_adc_start_q,
    // analog outputs and pin drive
    output reg wind_speed_ao_en_q,
    output reg wind_direction_ao_en_q,
    output wire pin_one_ao_drive_q,
    output wire pin_four_ao_drive_q,
    // serial and id
    output reg half_duplex_q,
    output reg full_duplex_ok_q,
    output reg [1:0] instrument_id_bit_q,
    output reg [1:0] instrument_id_valid_q,
    // telegram field
    output reg [W-1:0] telegram_field_q
);
    localparam integer PERIOD_CYC = SAMPLE_PERIOD_NS / `MFP_CLK_PERIOD_NS;
    localparam [1:0] TRANS_NONSEQ = 2'b10;
    localparam [1:0] TRANS_SEQ = 2'b11;

    // code acceptance check, used for both pins
    function code_ok;
        input [31:0] v;
        begin
            code_ok = (v[31:3] == 29'h0) && (v[2:0] <= `MFP_CODE_MAX);
        end
    endfunction

    reg [4:0] ctrl_q;
    reg [2:0] pin_one_function_q;
    reg [2:0] pin_four_function_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;
    wire half = ctrl_q[`MFP_CTRL_HALF_BIT];
    wire [1:0] analog_output_mode = ctrl_q[`MFP_CTRL_AN_HI:`MFP_CTRL_AN_LO];
    wire external_id_select = ctrl_q[`MFP_CTRL_XID_BIT];

    wire one_lvl;
    wire four_lvl;
    wire [W-1:0] one_value;
    wire [W-1:0] four_value;
    wire [W-1:0] one_test;
    wire [W-1:0] four_test;
    wire one_ao_off;
    wire four_ao_off;
    wire one_id;
    wire four_id;
    wire one_idv;
    wire four_idv;

    mfp_sync u_sync_one (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(pin_one_in),
        .q(one_lvl)
    );

    mfp_sync u_sync_four (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .d(pin_four_in),
        .q(four_lvl)
    );

    mfp_pin #(.PERIOD(PERIOD_CYC), .W(W)) u_pin_one (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .code(pin_one_function_q),
        .half_duplex(half),
        .an_mode(analog_output_mode),
        .ext_id_sel(external_id_select),
        .pin_level(one_lvl),
        .adc_data(pin_one_adc_data),
        .adc_valid(pin_one_adc_valid),
        .adc_start_q(pin_one_adc_start_q),
        .value_q(one_value),
        .selftest_q(one_test),
        .ao_off_q(one_ao_off),
        .ao_drive_q(pin_one_ao_drive_q),
        .id_bit_q(one_id),
        .id_valid_q(one_idv)
    );

    mfp_pin #(.PERIOD(PERIOD_CYC), .W(W)) u_pin_four (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .code(pin_four_function_q),
        .half_duplex(half),
        .an_mode(analog_output_mode),
        .ext_id_sel(external_id_select),
        .pin_level(four_lvl),
        .adc_data(pin_four_adc_data),
        .adc_valid(pin_four_adc_valid),
        .adc_start_q(pin_four_adc_start_q),
        .value_q(four_value),
        .selftest_q(four_test),
        .ao_off_q(four_ao_off),
        .ao_drive_q(pin_four_ao_drive_q),
        .id_bit_q(four_id),
        .id_valid_q(four_idv)
    );

    // status word
    wire [31:0] status = {22'h0, four_idv, four_id, one_idv, one_id,
        full_duplex_ok_q, wind_direction_ao_en_q, wind_speed_ao_en_q,
        pin_four_ao_drive_q, pin_one_ao_drive_q, half};

    // read data for the address in the address phase
    reg [31:0] rd_d;
    always @* begin
        rd_d = 32'h0;
        case (haddr)
            `MFP_CTRL_OFS: rd_d = {27'h0, ctrl_q};
            `MFP_PIN_ONE_FUNC_OFS: rd_d = {29'h0, pin_one_function_q};
            `MFP_PIN_FOUR_FUNC_OFS: rd_d = {29'h0, pin_four_function_q};
            `MFP_STATUS_OFS: rd_d = status;
            `MFP_PIN_ONE_VALUE_OFS: rd_d = {{(32-W){1'b0}}, one_value};
            `MFP_PIN_FOUR_VALUE_OFS: rd_d = {{(32-W){1'b0}}, four_value};
            `MFP_TELEGRAM_OFS: rd_d = {{(32-W){1'b0}}, telegram_field_q};
            default: rd_d = 32'h0;
        endcase
    end

    wire take = hsel && hready && ((htrans == TRANS_NONSEQ) || (htrans == TRANS_SEQ));

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h0;
            ctrl_q <= `MFP_CTRL_RESET;
            pin_one_function_q <= `MFP_CODE_RESET;
            pin_four_function_q <= `MFP_CODE_RESET;
            wind_speed_ao_en_q <= 1'b0;
            wind_direction_ao_en_q <= 1'b0;
            half_duplex_q <= 1'b0;
            full_duplex_ok_q <= 1'b1;
            instrument_id_bit_q <= 2'h0;
            instrument_id_valid_q <= 2'h0;
            telegram_field_q <= {W{1'b0}};
        end else if (ce) begin
            // address phase: capture write, present read data
            wr_pend_q <= take && hwrite;
            wr_addr_q <= haddr;
            if (take && !hwrite)
                hrdata <= rd_d;
            // data phase: store write data
            if (wr_pend_q) begin
                case (wr_addr_q)
                    `MFP_CTRL_OFS: ctrl_q <= hwdata[4:0];
                    `MFP_PIN_ONE_FUNC_OFS:
                        if (half && code_ok(hwdata))
                            pin_one_function_q <= hwdata[2:0];
                    `MFP_PIN_FOUR_FUNC_OFS:
                        if (half && code_ok(hwdata))
                            pin_four_function_q <= hwdata[2:0];
                    default: ;
                endcase
            end
            // derived pin outcomes
            half_duplex_q <= half;
            full_duplex_ok_q <= (pin_one_function_q == `MFP_CODE_UNUSED)
                && (pin_four_function_q == `MFP_CODE_UNUSED);
            wind_speed_ao_en_q <= !one_ao_off
                && (analog_output_mode != `MFP_AN_OFF);
            wind_direction_ao_en_q <= !four_ao_off
                && (analog_output_mode != `MFP_AN_OFF);
            instrument_id_bit_q <= {four_id, one_id};
            instrument_id_valid_q <= {four_idv, one_idv};
            telegram_field_q <= ctrl_q[`MFP_CTRL_TEL_BIT] ? four_test : one_test;
        end
    end
endmodule // mfp_top
`default_nettype wire
